// ===== logic/sgbp_port.sv
// Scatter/gather buffer port between the 64-bit data bus and a 32-bit bus.
// What this block does
// - A 64-bit staging buffer serves reads, bus-master loads and dumps; processor writes bypass it.
// - Byte-enable float request floats byte enables from the following clock.
// - Under byte-enable float only byte enables stop; bus cycles keep going.
// - Outside logic drives byte enables; they are sampled every edge while floated.
// - Processor write drives buffer data in the same clock as its byte enables.
// - Loads and reads capture the data bus one clock after an enable.
// - A dump drives the selected bytes one clock after the sampled byte enables.
// - Inbound FF nothing, Fx low to low, xF low to high, else all.
// - Outbound FF nothing, Fx low to low, xF high to low, else all.
// - Local write with low byte enables off copies upper dword onto lower lanes.
// - Data-bus float request floats data and parity from the following clock.
// - Under data float only data and parity stop; cycles complete on burst ready.
// - Local-bus access flags every I/O cycle and every local-region access.
// - Local-bus access asserts with the address strobe for exactly one clock.
// - Dump pins are enabled only if dump request is low at reset release.
// - Address float request floats address and address parity next clock.
`timescale 1ns/1ps
module sgbp_port #(
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Float and dump requests from the system
  input wire logic i_byte_enable_float_request,
  input wire logic i_data_bus_float_request,
  input wire logic i_address_float_request,
  input wire logic i_buffer_dump_request_n,
  // Processor core side of the bus
  input wire logic i_core_cycle_start,
  input wire logic i_core_write,
  input wire logic i_core_io,
  input wire logic i_core_local_region,
  input wire logic [sgbp_pkg::ADDR_HI_W-1:0] i_core_addr,
  input wire logic i_core_addr_parity,
  input wire logic [sgbp_pkg::BE_W-1:0] i_core_be_n,
  input wire logic [sgbp_pkg::DATA_W-1:0] i_core_wdata,
  input wire logic [sgbp_pkg::DP_W-1:0] i_core_wparity,
  input wire logic i_burst_ready_n,
  // Read words towards the core, buffered
  output logic o_rd_valid,
  input wire logic i_rd_ready,
  output logic [sgbp_pkg::DATA_W-1:0] o_rd_data,
  output logic o_rd_cycle_done,
  // Pins: address, byte enables, data
  output logic [sgbp_pkg::ADDR_HI_W-1:0] o_addr,
  output logic o_address_parity,
  output logic o_addr_oe_n,
  output logic o_address_strobe_n,
  output logic o_local_bus_access_n,
  input wire logic [sgbp_pkg::BE_W-1:0] i_byte_enable_lanes_n,
  output logic [sgbp_pkg::BE_W-1:0] o_byte_enable_lanes_n,
  output logic o_be_oe_n,
  input wire logic [sgbp_pkg::DATA_W-1:0] i_data,
  output logic [sgbp_pkg::DATA_W-1:0] o_data,
  output logic [sgbp_pkg::DP_W-1:0] o_data_parity,
  output logic o_data_oe_n,
  // Status
  output logic o_dump_enabled,
  output logic o_stall
);

  typedef struct packed {
    logic [63:0] sg_buf;
    logic [63:0] dout;
    logic [7:0] dpar;
    logic [7:0] be_out;
    logic [28:0] addr;
    logic ap;
    logic drive_data;
    logic float_be;
    logic float_d;
    logic float_a;
    logic strobe;
    logic lba;
    logic dump_en;
    logic rst_seen;
    logic dump_prev;
    sgbp_pkg::sgbp_xfer_e pend;
    logic [7:0] pend_be;
  } sgbp_port_s;

  sgbp_port_s state_reg;
  sgbp_port_s state_next;

  logic bef_s;
  logic df_s;
  logic af_s;
  logic dump_s;
  logic fifo_in_valid;
  logic fifo_in_ready;
  logic [63:0] fifo_in_data;

  // ----------------------------------------
  // Pin input synchronisers
  // ----------------------------------------
  sgbp_sync3 u_sync_bef (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pin(i_byte_enable_float_request),
    .i_rst_level(1'b0), .o_level(bef_s)
  );
  sgbp_sync3 u_sync_df (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pin(i_data_bus_float_request),
    .i_rst_level(1'b0), .o_level(df_s)
  );
  sgbp_sync3 u_sync_af (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pin(i_address_float_request),
    .i_rst_level(1'b0), .o_level(af_s)
  );
  sgbp_sync3 u_sync_dump (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_pin(~i_buffer_dump_request_n),
    .i_rst_level(1'b0), .o_level(dump_s)
  );

  // ----------------------------------------
  // Byte-lane mapping helpers
  // ----------------------------------------
  function automatic logic [63:0] map_in(input logic [7:0] be_n, input logic [63:0] d,
                                         input logic [63:0] b);
    logic [63:0] r;
    r = b;
    if (be_n == sgbp_pkg::BE_NONE) begin
      r = b;
    end else if (be_n[7:4] == sgbp_pkg::NIB_OFF) begin
      r[31:0] = d[31:0];
    end else if (be_n[3:0] == sgbp_pkg::NIB_OFF) begin
      r[63:32] = d[31:0];
    end else begin
      r = d;
    end
    return r;
  endfunction : map_in

  function automatic logic [63:0] map_out(input logic [7:0] be_n, input logic [63:0] b);
    logic [63:0] r;
    r = b;
    if (be_n[7:4] == sgbp_pkg::NIB_OFF) begin
      r = {32'h0000_0000, b[31:0]};
    end else if (be_n[3:0] == sgbp_pkg::NIB_OFF) begin
      r = {32'h0000_0000, b[63:32]};
    end
    return r;
  endfunction : map_out

  function automatic logic [7:0] par8(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) begin
      p[i] = ^d[i*8 +: 8];
    end
    return p;
  endfunction : par8

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    state_next = state_reg;
    fifo_in_valid = 1'b0;
    fifo_in_data = state_reg.sg_buf;
    state_next.float_be = bef_s;
    state_next.float_d = df_s;
    state_next.float_a = af_s;
    state_next.dump_prev = dump_s;
    state_next.strobe = 1'b0;
    state_next.lba = 1'b0;
    state_next.drive_data = 1'b0;
    state_next.pend = sgbp_pkg::SGBP_XF_NONE;
    // Strap caught on the first clock after reset release.
    state_next.rst_seen = 1'b1;
    if (!state_reg.rst_seen) begin
      state_next.dump_en = dump_s;
    end
    // Processor cycles keep starting whatever the floats say.
    if (i_core_cycle_start && !o_stall) begin
      state_next.strobe = 1'b1;
      state_next.addr = i_core_addr;
      state_next.ap = i_core_addr_parity;
      state_next.be_out = i_core_be_n;
      state_next.lba = i_core_io || i_core_local_region;
      if (i_core_write) begin
        state_next.drive_data = 1'b1;
        state_next.dout = i_core_wdata;
        state_next.dpar = i_core_wparity;
        if ((i_core_io || i_core_local_region) && i_core_be_n[3:0] == sgbp_pkg::NIB_OFF) begin
          state_next.dout[31:0] = i_core_wdata[63:32];
        end
      end
    end
    // Scatter/gather side: enables sampled every edge while floated.
    if (state_reg.float_be && i_byte_enable_lanes_n != sgbp_pkg::BE_NONE) begin
      state_next.pend_be = i_byte_enable_lanes_n;
      if (state_reg.dump_en && dump_s) begin
        state_next.pend = sgbp_pkg::SGBP_XF_DUMP;
      end else begin
        state_next.pend = sgbp_pkg::SGBP_XF_LOAD;
      end
    end
    case (state_reg.pend)
      sgbp_pkg::SGBP_XF_LOAD: begin
        // Capture one clock after the enable; untouched bytes are kept.
        state_next.sg_buf = map_in(state_reg.pend_be, i_data, state_reg.sg_buf);
        fifo_in_valid = 1'b1;
        fifo_in_data = map_in(state_reg.pend_be, i_data, state_reg.sg_buf);
      end
      sgbp_pkg::SGBP_XF_DUMP: begin
        state_next.drive_data = 1'b1;
        state_next.dout = map_out(state_reg.pend_be, state_reg.sg_buf);
        state_next.dpar = par8(map_out(state_reg.pend_be, state_reg.sg_buf));
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= '0;
      state_reg.sg_buf <= sgbp_pkg::BUF_RESET;
      state_reg.be_out <= sgbp_pkg::BE_NONE;
      state_reg.pend_be <= sgbp_pkg::BE_NONE;
    end else begin
      state_reg <= state_next;
    end
  end

  // ----------------------------------------
  // Read-word buffer towards the core
  // ----------------------------------------
  sgbp_fifo2 #(.WIDTH(sgbp_pkg::DATA_W), .DEPTH(DEPTH)) u_fifo (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_in_valid(fifo_in_valid), .o_in_ready(fifo_in_ready), .i_in_data(fifo_in_data),
    .o_out_valid(o_rd_valid), .i_out_ready(i_rd_ready), .o_out_data(o_rd_data)
  );

  // New core cycles wait while the read buffer is full.
  assign o_stall = !fifo_in_ready;
  assign o_rd_cycle_done = !i_burst_ready_n && !state_reg.drive_data;

  // ----------------------------------------
  // Pin outputs
  // ----------------------------------------
  assign o_addr = state_reg.addr;
  assign o_address_parity = state_reg.ap;
  assign o_addr_oe_n = state_reg.float_a;
  assign o_address_strobe_n = !state_reg.strobe;
  assign o_local_bus_access_n = !state_reg.lba;
  assign o_byte_enable_lanes_n = state_reg.be_out;
  assign o_be_oe_n = state_reg.float_be;
  assign o_data = state_reg.dout;
  assign o_data_parity = state_reg.dpar;
  assign o_data_oe_n = state_reg.float_d || !state_reg.drive_data;
  assign o_dump_enabled = state_reg.dump_en;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  sequence be_seen_s;
    state_reg.float_be && i_byte_enable_lanes_n != sgbp_pkg::BE_NONE;
  endsequence

  be_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    bef_s |=> o_be_oe_n) else $error("byte enables not floated");
  data_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    df_s |=> o_data_oe_n) else $error("data bus not floated");
  addr_float_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    af_s |=> o_addr_oe_n) else $error("address not floated");
  lba_one_clock_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    !o_local_bus_access_n |-> !o_address_strobe_n ##1 o_local_bus_access_n)
    else $error("local access not one clock with strobe");
  lba_io_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (i_core_cycle_start && !o_stall && i_core_io) |=> !o_local_bus_access_n)
    else $error("io cycle missing local access");
  load_capture_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (be_seen_s and !(state_reg.dump_en && dump_s)) |=> ##1
    state_reg.sg_buf == map_in($past(i_byte_enable_lanes_n, 2), $past(i_data),
                               $past(state_reg.sg_buf)))
    else $error("load not captured one clock later");
  dump_drive_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    (be_seen_s and (state_reg.dump_en && dump_s)) |=> ##1 state_reg.drive_data)
    else $error("dump not driven one clock later");
  buf_hold_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg.pend != sgbp_pkg::SGBP_XF_LOAD |=> $stable(state_reg.sg_buf))
    else $error("buffer changed without a load");

endmodule : sgbp_port

// ===== logic/sgbp_pkg.sv
// Package of constants and types for the scatter/gather buffer port.
package sgbp_pkg;

  // ----------------------------------------
  // Widths
  // ----------------------------------------
  localparam int DATA_W = 64;
  localparam int HALF_W = 32;
  localparam int BE_W = 8;
  localparam int DP_W = 8;
  localparam int ADDR_HI_W = 29;

  // ----------------------------------------
  // Reset values and patterns
  // ----------------------------------------
  localparam logic [63:0] BUF_RESET = 64'h0000_0000_0000_0000;
  localparam logic [7:0] BE_NONE = 8'hff;
  localparam logic [3:0] NIB_OFF = 4'hf;
  localparam logic [2:0] SYNC_RESET = 3'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int DATA_LAG_NS = 25;
  localparam int DATA_LAG_CYC = (DATA_LAG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------
  // Transfer kinds held by the pipeline
  // ----------------------------------------
  typedef enum logic [1:0] {
    SGBP_XF_NONE,
    SGBP_XF_LOAD,
    SGBP_XF_DUMP
  } sgbp_xfer_e;

endpackage : sgbp_pkg

// ===== logic/sgbp_sync3.sv
// Three-stage synchroniser for one pin input.
`timescale 1ns/1ps
module sgbp_sync3 (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Pin and settled level
  input wire logic i_pin,
  input wire logic i_rst_level,
  output logic o_level
);

  typedef struct packed {
    logic [2:0] stage;
    logic level;
  } sgbp_sync_s;

  sgbp_sync_s state_reg;
  sgbp_sync_s state_next;

  always_comb begin
    state_next = state_reg;
    state_next.stage = {state_reg.stage[1:0], i_pin};
    // A change counts once the second and third stages agree.
    if (state_reg.stage[1] == state_reg.stage[2]) begin
      state_next.level = state_reg.stage[2];
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      // Stages keep tracking the pin during reset, so a strap is settled at release.
      state_reg.stage <= state_next.stage;
      state_reg.level <= (state_reg.stage[1] == state_reg.stage[2]) ?
                         state_reg.stage[2] : i_rst_level;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_level = state_reg.level;

endmodule : sgbp_sync3

// ===== logic/sgbp_fifo2.sv
// Small valid/ready buffer, two entries by default.
`timescale 1ns/1ps
module sgbp_fifo2 #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  // Clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_n,
  // Filling side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // Draining side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } sgbp_fifo_s;

  sgbp_fifo_s state_reg;
  sgbp_fifo_s state_next;
  logic push;
  logic pop;

  assign o_in_ready = state_reg.cnt != (PW+1)'(DEPTH);
  assign o_out_valid = state_reg.cnt != '0;
  assign o_out_data = state_reg.mem[state_reg.rp];
  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;

  always_comb begin
    state_next = state_reg;
    if (push) begin
      state_next.mem[state_reg.wp] = i_in_data;
      state_next.wp = (state_reg.wp == PW'(DEPTH - 1)) ? '0 : state_reg.wp + PW'(1);
    end
    if (pop) begin
      state_next.rp = (state_reg.rp == PW'(DEPTH - 1)) ? '0 : state_reg.rp + PW'(1);
    end
    state_next.cnt = state_reg.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg <= '0;
    end else begin
      state_reg <= state_next;
    end
  end

  fifo_bound_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
    state_reg.cnt <= (PW+1)'(DEPTH)) else $error("buffer count overflow");

endmodule : sgbp_fifo2

// ===== testbench/sgbp_partner.sv
// Model of the system logic that drives the 32-bit side of the buffer port.
`timescale 1ns/1ps
module sgbp_partner (
  // Clock
  input wire logic i_clk_sys,
  // Pins driven towards the port
  output logic o_byte_enable_float_request,
  output logic o_data_bus_float_request,
  output logic o_address_float_request,
  output logic o_buffer_dump_request_n,
  output logic [7:0] o_byte_enable_lanes_n,
  output logic [63:0] o_data
);
  initial begin
    o_byte_enable_float_request = 1'b0;
    o_data_bus_float_request = 1'b0;
    o_address_float_request = 1'b0;
    o_buffer_dump_request_n = 1'b0;
    o_byte_enable_lanes_n = 8'hff;
    o_data = 64'h5a5a_5a5a_5a5a_5a5a;
  end

  task automatic settle();
    repeat (6) @(posedge i_clk_sys);
  endtask : settle

  // Byte enables are floated only together with the address.
  task automatic floats(input logic a, input logic d);
    @(posedge i_clk_sys);
    o_address_float_request <= a;
    o_byte_enable_float_request <= a;
    o_data_bus_float_request <= d;
    settle();
  endtask : floats

  task automatic strap_off();
    @(posedge i_clk_sys);
    o_buffer_dump_request_n <= 1'b1;
    settle();
  endtask : strap_off

  // Dumping needs the data bus handed back to the port.
  task automatic dump_mode(input logic on);
    @(posedge i_clk_sys);
    o_buffer_dump_request_n <= !on;
    o_data_bus_float_request <= !on;
    settle();
  endtask : dump_mode

  // One enable beat; the data stays over the edge after the enables, then is inverted.
  task automatic beat(input logic [7:0] be, input logic [63:0] d);
    @(posedge i_clk_sys);
    o_byte_enable_lanes_n <= be;
    o_data <= d;
    @(posedge i_clk_sys);
    o_byte_enable_lanes_n <= 8'hff;
    @(posedge i_clk_sys);
    o_data <= ~d;
  endtask : beat
endmodule : sgbp_partner

// ===== testbench/tb.sv
// Self-checking bench for the scatter/gather buffer port.
`timescale 1ns/1ps
module tb;
  logic i_clk_sys = 1'b0;
  logic i_rst_n = 1'b0;
  logic start = 1'b0, wr = 1'b0, io = 1'b0, loc = 1'b0, rdy = 1'b0, burst_ready_n_n = 1'b1;
  logic [7:0] cbe_n = 8'hff;
  logic [63:0] wdat = 64'h1111_2222_3333_4444;
  logic [63:0] buf_exp = sgbp_pkg::BUF_RESET;
  logic rd_valid, rd_done, as_n, lba_n, aoe_n, beoe_n, doe_n, dump_en, stall, ap;
  logic bef, dbf, adf, dmp_n;
  logic [63:0] rd_data, dout, dwire, pdata;
  logic [7:0] beout, pbe, bewire, dpar;
  logic [28:0] aout;
  int n_errors = 0, compares = 0, cycles = 0;

  assign dwire = doe_n ? pdata : dout;
  assign bewire = beoe_n ? pbe : beout;
  always #12.5 i_clk_sys = ~i_clk_sys;

  sgbp_port i_sgbp_port (
    .i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n),
    .i_byte_enable_float_request(bef), .i_data_bus_float_request(dbf),
    .i_address_float_request(adf), .i_buffer_dump_request_n(dmp_n),
    .i_core_cycle_start(start), .i_core_write(wr), .i_core_io(io),
    .i_core_local_region(loc), .i_core_addr(29'h0123_4567),
    .i_core_addr_parity(1'b0), .i_core_be_n(cbe_n), .i_core_wdata(wdat),
    .i_core_wparity(8'h00), .i_burst_ready_n(burst_ready_n_n),
    .o_rd_valid(rd_valid), .i_rd_ready(rdy), .o_rd_data(rd_data),
    .o_rd_cycle_done(rd_done), .o_addr(aout), .o_address_parity(ap),
    .o_addr_oe_n(aoe_n), .o_address_strobe_n(as_n), .o_local_bus_access_n(lba_n),
    .i_byte_enable_lanes_n(bewire), .o_byte_enable_lanes_n(beout), .o_be_oe_n(beoe_n),
    .i_data(dwire), .o_data(dout), .o_data_parity(dpar), .o_data_oe_n(doe_n),
    .o_dump_enabled(dump_en), .o_stall(stall)
  );

  sgbp_partner i_sgbp_partner (
    .i_clk_sys(i_clk_sys), .o_byte_enable_float_request(bef),
    .o_data_bus_float_request(dbf), .o_address_float_request(adf),
    .o_buffer_dump_request_n(dmp_n), .o_byte_enable_lanes_n(pbe), .o_data(pdata)
  );

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Even parity of each data byte.
  function automatic logic [7:0] par_exp(input logic [63:0] d);
    logic [7:0] p;
    p = 8'h00;
    for (int i = 0; i < 8; i++) p[i] = ^d[i*8 +: 8];
    return p;
  endfunction : par_exp

  task automatic finish_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : finish_test

  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_errors++;
      finish_test();
    end
  end

  // Polls for data driven (drv) or a read word waiting, for up to eight cycles.
  task automatic wait_ev(input logic drv, output logic seen);
    for (int k = 0; k < 8; k++) begin
      seen = drv ? (doe_n === 1'b0) : (rd_valid === 1'b1);
      if (seen) break;
      @(posedge i_clk_sys);
      #1;
    end
  endtask : wait_ev

  task automatic pop();
    @(posedge i_clk_sys);
    rdy <= 1'b1;
    @(posedge i_clk_sys);
    rdy <= 1'b0;
    #1;
  endtask : pop

  task automatic core(input logic w, input logic i, input logic l, input logic [7:0] be);
    logic seen;
    @(posedge i_clk_sys);
    start <= 1'b1;
    wr <= w;
    io <= i;
    loc <= l;
    cbe_n <= be;
    @(posedge i_clk_sys);
    start <= 1'b0;
    #1;
    chk(as_n, 1'b0);
    chk(lba_n, !(i | l));
    chk({ap, aout}, {1'b0, 29'h0123_4567});
    chk(beout, be);
    if (w) begin
      wait_ev(1'b1, seen);
      chk(seen, 1'b1);
      chk(dout[31:0], wdat[63:32]);
    end else begin
      @(posedge i_clk_sys);
      #1;
      chk({as_n, lba_n}, 2'h3);
    end
    @(posedge i_clk_sys);
    burst_ready_n_n <= 1'b0;
    #1;
    if (!w) chk(rd_done, 1'b1);
    @(posedge i_clk_sys);
    burst_ready_n_n <= 1'b1;
  endtask : core

  task automatic t_float();
    i_sgbp_partner.floats(1'b1, 1'b1);
    #1;
    chk({aoe_n, beoe_n, doe_n}, 3'h7);
    core(1'b0, 1'b0, 1'b1, 8'h00);
    i_sgbp_partner.floats(1'b0, 1'b1);
    core(1'b0, 1'b1, 1'b0, 8'h00);
    chk({aoe_n, beoe_n, doe_n}, 3'h1);
    i_sgbp_partner.floats(1'b0, 1'b0);
  endtask : t_float

  task automatic t_lba();
    core(1'b0, 1'b0, 1'b0, 8'h00);
    core(1'b0, 1'b0, 1'b1, 8'h00);
    core(1'b0, 1'b1, 1'b0, 8'h00);
    core(1'b1, 1'b0, 1'b1, 8'h0f);
  endtask : t_lba

  // Reader stalls: two words fit, the third is dropped and starts are held off.
  task automatic t_fifo();
    i_sgbp_partner.floats(1'b1, 1'b1);
    for (int k = 0; k < 3; k++) i_sgbp_partner.beat(8'h00, 64'h0a0b_0c0d_0000_0000 + k);
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk(stall, 1'b1);
    chk(rd_data, 64'h0a0b_0c0d_0000_0000);
    pop();
    chk(rd_valid, 1'b1);
    chk(rd_data, 64'h0a0b_0c0d_0000_0001);
    pop();
    chk({rd_valid, stall}, 2'h0);
    buf_exp = 64'h0a0b_0c0d_0000_0002;
  endtask : t_fifo

  task automatic t_load();
    logic [7:0] bes [4] = '{8'hff, 8'h5a, 8'hf0, 8'h0f};
    logic [63:0] d;
    logic seen;
    for (int k = 0; k < 4; k++) begin
      d = 64'h1357_9bdf_2468_ace0 + k;
      i_sgbp_partner.beat(bes[k], d);
      case (bes[k])
        8'hff: ;
        8'hf0: buf_exp[31:0] = d[31:0];
        8'h0f: buf_exp[63:32] = d[31:0];
        default: buf_exp = d;
      endcase
      #1;
      wait_ev(1'b0, seen);
      chk(seen, bes[k] != 8'hff);
      if (seen) chk(rd_data, buf_exp);
      if (seen) pop();
    end
  endtask : t_load

  task automatic t_dump();
    logic [7:0] bes [4] = '{8'hff, 8'hf0, 8'h0f, 8'h5a};
    logic seen;
    i_sgbp_partner.dump_mode(1'b1);
    for (int k = 0; k < 4; k++) begin
      i_sgbp_partner.beat(bes[k], 64'h0);
      #1;
      wait_ev(1'b1, seen);
      chk(seen, bes[k] != 8'hff);
      case (bes[k])
        8'hff: ;
        8'hf0: chk(dout[31:0], buf_exp[31:0]);
        8'h0f: chk(dout[31:0], buf_exp[63:32]);
        default: chk(dout, buf_exp);
      endcase
      if (bes[k] == 8'h5a) chk(dpar, par_exp(buf_exp));
      repeat (3) @(posedge i_clk_sys);
    end
    i_sgbp_partner.dump_mode(1'b0);
    i_sgbp_partner.floats(1'b0, 1'b0);
  endtask : t_dump

  initial begin
    repeat (11) @(posedge i_clk_sys);
    #1;
    chk({as_n, lba_n, doe_n}, 3'h7);
    @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    repeat (6) @(posedge i_clk_sys);
    i_sgbp_partner.strap_off();
    #1;
    chk(dump_en, 1'b1);
    t_float();
    t_lba();
    t_fifo();
    t_load();
    t_dump();
    finish_test();
  end
endmodule : tb
